// file: src/ecic_pkg.sv
// Purpose: Shared constants and types for the event count / interval capture channel.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes: Mode and edge-select encodings are local to this block.
package ecic_pkg;
   // Counter width and the key counter values.
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_FULL = 16'hFFFF;
   // Reset value of the data register.
   localparam logic [15:0] DATA_RST = 16'h0000;
   // Bit position of the wrap flag in the status register.
   localparam int STAT_WRAP_BIT = 0;
   // Start trigger select code for edge-started capture.
   localparam logic [2:0] STS_EDGE = 3'h1;
   // Edge select codes.
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   // Input synchroniser depth.
   localparam int SYNC_STAGES = 3;

   // Channel function.
   typedef enum logic [0:0] {
      ECIC_MODE_EVENT = 1'b0,
      ECIC_MODE_CAPTURE = 1'b1
   } ecic_mode_e;

   // Channel state, one-hot.
   typedef enum logic [2:0] {
      ECIC_ST_IDLE = 3'b001,
      ECIC_ST_LOAD = 3'b010,
      ECIC_ST_RUN = 3'b100
   } ecic_state_e;
endpackage : ecic_pkg

// file: src/ecic_edge_detect.sv
// Purpose: Synchronise the timer input pin and report selected edges.
// Assumes: Pin is asynchronous to core_clk_in.
// Notes: An edge counts once the second and third stages agree on a new level.
module ecic_edge_detect (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Pin and edge selection.
   input wire logic timer_input_pin_in,
   input wire logic [1:0] edge_sel_in,
   // Detected edge, one-cycle pulse.
   output logic edge_out
);
   import ecic_pkg::*;

   // State: synchroniser chain and the last accepted level.
   typedef struct packed {
      logic [SYNC_STAGES-1:0] sync;
      logic level;
   } ecic_sync_s;

   ecic_sync_s st_q, st_d;
   logic rise, fall;

   // Next-state logic; only stage two and three feed the level decision.
   always_comb begin
      st_d = st_q;
      st_d.sync = {st_q.sync[SYNC_STAGES-2:0], timer_input_pin_in};
      if (st_q.sync[1] == st_q.sync[2]) begin
         st_d.level = st_q.sync[2];
      end
   end

   // State register.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rise = st_d.level & ~st_q.level;
   assign fall = ~st_d.level & st_q.level;

   // Edge selection; the detected pulse comes from the next-state level, a cycle ahead of the level register.
   always_comb begin
      unique case (edge_sel_in)
         EDGE_FALL: edge_out = fall;
         EDGE_RISE: edge_out = rise;
         default: edge_out = rise | fall;
      endcase
   end
endmodule // ecic_edge_detect

// file: src/ecic_channel.sv
// Purpose: One timer channel: external event counter or input pulse interval capture.
// Assumes: Software bits arrive as plain ports; the clock gating of the unit is modelled as a reset.
// Notes: Each core clock is one count clock.
module ecic_channel (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Unit peripheral enable.
   input wire logic unit_enable_in,
   // Software triggers and configuration.
   input wire logic channel_start_trigger_in,
   input wire logic channel_stop_trigger_in,
   input wire ecic_pkg::ecic_mode_e mode_in,
   input wire logic mode_low_bit_in,
   input wire logic [1:0] edge_sel_in,
   input wire logic [2:0] start_trigger_select_in,
   input wire logic data_write_in,
   input wire logic [15:0] data_wdata_in,
   // External pin.
   input wire logic timer_input_pin_in,
   // Status and data.
   output logic channel_enable_status_out,
   output logic [15:0] channel_counter_out,
   output logic [15:0] channel_data_register_out,
   output logic [15:0] channel_status_register_out,
   output logic channel_interrupt_out
);
   import ecic_pkg::*;

   // Whole channel state.
   typedef struct packed {
      ecic_state_e state;
      logic enable;
      logic [15:0] counter;
      logic [15:0] data;
      logic wrap_flag;
      logic wrap_seen;
      logic irq;
   } ecic_chan_s;

   ecic_chan_s st_q, st_d;
   logic edge_hit;
   logic dis_rst;
   // Counter plus one, with the carry out of bit 15 kept as the wrap indication.
   logic [16:0] cnt_inc;

   // Disabling the unit acts as a reset of the channel and its synchroniser.
   assign dis_rst = sys_rst_in | ~unit_enable_in;

   // Input sampled on the operating clock through the synchroniser.
   ecic_edge_detect u_edge (
      .core_clk_in(core_clk_in),
      .sys_rst_in(dis_rst),
      .timer_input_pin_in(timer_input_pin_in),
      .edge_sel_in(edge_sel_in),
      .edge_out(edge_hit)
   );

   // Increment with wrap detection.
   function automatic logic [16:0] inc16(input logic [15:0] v);
      inc16 = {1'b0, v} + 17'h00001;
   endfunction

   // The sum is held in a net so that the counter and the wrap bit are plain part-selects.
   assign cnt_inc = inc16(st_q.counter);

   // Next-state logic.
   always_comb begin
      st_d = st_q;
      st_d.irq = 1'b0;
      // Data writes land any time in event mode and are dropped in capture mode; the counter only sees them at start or a reload.
      if (data_write_in && mode_in == ECIC_MODE_EVENT) begin
         st_d.data = data_wdata_in;
      end
      unique case (st_q.state)
         ECIC_ST_IDLE: begin
            if (channel_start_trigger_in) begin
               st_d.enable = 1'b1;
               st_d.state = ECIC_ST_LOAD;
            end
         end
         ECIC_ST_LOAD: begin
            // First count clock after start.
            st_d.state = ECIC_ST_RUN;
            if (mode_in == ECIC_MODE_EVENT) begin
               st_d.counter = st_d.data;
            end else begin
               st_d.counter = CNT_ZERO;
               st_d.wrap_seen = 1'b0;
               st_d.irq = mode_low_bit_in;
            end
         end
         ECIC_ST_RUN: begin
            if (mode_in == ECIC_MODE_EVENT) begin
               if (edge_hit) begin
                  if (st_q.counter == CNT_ZERO) begin
                     st_d.counter = st_d.data;
                     st_d.irq = 1'b1;
                  end else begin
                     st_d.counter = st_q.counter - 16'h0001;
                  end
               end
            end else if (edge_hit || channel_start_trigger_in) begin
               // Capture by pin edge or by software start.
               st_d.data = st_q.counter;
               st_d.counter = CNT_ZERO;
               st_d.irq = 1'b1;
               st_d.wrap_flag = st_q.wrap_seen;
               st_d.wrap_seen = 1'b0;
            end else begin
               st_d.counter = cnt_inc[15:0];
               if (cnt_inc[16]) begin
                  st_d.wrap_seen = 1'b1;
               end
            end
         end
         default: st_d.state = ECIC_ST_IDLE;
      endcase
      // Stop wins over start and capture, though a capture still loads the data register; counter and wrap flag are held.
      if (channel_stop_trigger_in) begin
         st_d.enable = 1'b0;
         st_d.state = ECIC_ST_IDLE;
         st_d.counter = st_q.counter;
         // A capture in the same cycle must not disturb the held flag.
         st_d.wrap_flag = st_q.wrap_flag;
         st_d.irq = 1'b0;
      end
   end

   // State register; a disabled unit holds everything at its initial value.
   always_ff @(posedge core_clk_in) begin
      if (dis_rst) begin
         st_q <= '{state: ECIC_ST_IDLE, data: DATA_RST, default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs come straight from flip-flops; triggers are only pulses, so they never read back.
   assign channel_enable_status_out = st_q.enable;
   assign channel_counter_out = st_q.counter;
   assign channel_data_register_out = st_q.data;
   assign channel_status_register_out = {15'h0000, st_q.wrap_flag};
   assign channel_interrupt_out = st_q.irq;

   // Start from idle raises enable on the next edge.
   a_start_enable: assert property (@(posedge core_clk_in) disable iff (dis_rst)
      st_q.state == ECIC_ST_IDLE && channel_start_trigger_in && !channel_stop_trigger_in
      |=> channel_enable_status_out)
      else $error("Start did not set enable.");

   // Event mode decrement on edge.
   a_event_dec: assert property (@(posedge core_clk_in) disable iff (dis_rst)
      st_q.state == ECIC_ST_RUN && mode_in == ECIC_MODE_EVENT && edge_hit && !channel_stop_trigger_in
      && st_q.counter != CNT_ZERO |=> channel_counter_out == $past(st_q.counter) - 16'h0001)
      else $error("Event counter did not decrement.");

   // Event mode holds without edges.
   a_event_hold: assert property (@(posedge core_clk_in) disable iff (dis_rst)
      st_q.state == ECIC_ST_RUN && mode_in == ECIC_MODE_EVENT && !edge_hit
      |=> $stable(channel_counter_out))
      else $error("Event counter moved without edge.");

   // Reload and interrupt at zero.
   a_event_reload: assert property (@(posedge core_clk_in) disable iff (dis_rst)
      st_q.state == ECIC_ST_RUN && mode_in == ECIC_MODE_EVENT && edge_hit && !channel_stop_trigger_in
      && st_q.counter == CNT_ZERO |=> channel_interrupt_out && channel_counter_out == $past(st_d.data))
      else $error("No reload at zero.");

   // Stop clears enable and holds the counter.
   a_stop_hold: assert property (@(posedge core_clk_in) disable iff (dis_rst)
      channel_stop_trigger_in |=> !channel_enable_status_out && channel_counter_out == $past(st_q.counter))
      else $error("Stop did not halt channel.");

   // Capture copies and clears.
   a_capture_copy: assert property (@(posedge core_clk_in) disable iff (dis_rst)
      st_q.state == ECIC_ST_RUN && mode_in == ECIC_MODE_CAPTURE && edge_hit && !channel_stop_trigger_in
      |=> channel_data_register_out == $past(st_q.counter) && channel_counter_out == CNT_ZERO
      && channel_interrupt_out)
      else $error("Capture failed.");

   // Wrap flag at capture mirrors a wrap in the period.
   a_wrap_flag: assert property (@(posedge core_clk_in) disable iff (dis_rst)
      st_q.state == ECIC_ST_RUN && mode_in == ECIC_MODE_CAPTURE && edge_hit && !channel_stop_trigger_in
      |=> channel_status_register_out[STAT_WRAP_BIT] == $past(st_q.wrap_seen))
      else $error("Wrap flag wrong at capture.");

   // Capture start: counter cleared and interrupt per mode bit.
   a_cap_start: assert property (@(posedge core_clk_in) disable iff (dis_rst)
      st_q.state == ECIC_ST_LOAD && mode_in == ECIC_MODE_CAPTURE && !channel_stop_trigger_in
      |=> channel_counter_out == CNT_ZERO && channel_interrupt_out == $past(mode_low_bit_in))
      else $error("Capture start wrong.");

   // Event start: the first count clock loads the data register into the counter.
   a_event_load: assert property (@(posedge core_clk_in) disable iff (dis_rst)
      st_q.state == ECIC_ST_LOAD && mode_in == ECIC_MODE_EVENT && !channel_stop_trigger_in
      |=> channel_counter_out == $past(st_d.data))
      else $error("Event start did not preload the counter.");

   // Stop keeps the wrap flag.
   a_stop_flag: assert property (@(posedge core_clk_in) disable iff (dis_rst)
      channel_stop_trigger_in |=> $stable(channel_status_register_out))
      else $error("Stop changed wrap flag.");

   // Disabled unit reads initial state.
   a_unit_off: assert property (@(posedge core_clk_in)
      !unit_enable_in && !sys_rst_in |=> !channel_enable_status_out && channel_counter_out == CNT_ZERO)
      else $error("Unit disable did not initialise.");
endmodule // ecic_channel

// file: tb/ecic_pulse_src.sv
// Purpose: External pulse source model that drives the channel's timer input pin.
// Assumes: Toggle requests come from the bench at the falling edge of the clock.
// Notes: The pin moves only on request, so the spacing between edges is exact.
module ecic_pulse_src (
   // Clock.
   input wire logic core_clk_in,
   // Toggle request, one cycle long.
   input wire logic toggle_in,
   // Pin level seen by the channel.
   output logic timer_input_pin_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // The source rests low, so the first edge it makes is a rising one.
   // The pin changes just after a clock edge, like a source clocked from the same board oscillator.
   initial begin
      timer_input_pin_out = 1'b0;
      forever begin
         @(posedge core_clk_in);
         if (toggle_in) begin
            timer_input_pin_out <= ~timer_input_pin_out;
         end
      end
   end
endmodule // ecic_pulse_src

// file: tb/test_event_count_and_interval_capture.sv
// Purpose: Self-checking bench for the event count and interval capture channel.
// Assumes: Pin edges are spaced wider than the synchroniser delay.
// Notes: Every edge selection is used in event mode; capture mode uses both edges.
module test_event_count_and_interval_capture;
   timeunit 1ns;
   timeprecision 1ns;
   import ecic_pkg::*;

   logic clk, rst, uen, st, sp, mlb, dwr, tog, pin, en, irq;
   ecic_mode_e mode;
   logic [1:0] esel;
   logic [2:0] sts;
   logic [15:0] wdata, cnt, dat, stat;
   int miscompares = 0;
   int n_tests = 0;
   int irqs = 0;
   logic [31:0] lf = 32'h6C18127B;

   ecic_channel u_dut (.core_clk_in(clk), .sys_rst_in(rst), .unit_enable_in(uen),
      .channel_start_trigger_in(st), .channel_stop_trigger_in(sp), .mode_in(mode),
      .mode_low_bit_in(mlb), .edge_sel_in(esel), .start_trigger_select_in(sts),
      .data_write_in(dwr), .data_wdata_in(wdata), .timer_input_pin_in(pin),
      .channel_enable_status_out(en), .channel_counter_out(cnt),
      .channel_data_register_out(dat), .channel_status_register_out(stat),
      .channel_interrupt_out(irq));

   ecic_pulse_src u_src (.core_clk_in(clk), .toggle_in(tog), .timer_input_pin_out(pin));

   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Interrupts are single-cycle pulses, so they are tallied mid-cycle where they are settled.
   always @(negedge clk) begin
      if (irq === 1'b1) begin
         irqs++;
      end
   end

   // Random source for data values and pulse intervals.
   function automatic logic [31:0] step(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // Whether a change to the given level is a counted edge.
   function automatic bit hits(input logic [1:0] s, input logic lvl);
      return s[1] || (s[0] == lvl);
   endfunction

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Raise one input for a single cycle; callers let a cycle pass before reuse.
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Guards against a hang; the full run needs about 66200 cycles, dominated by the wrap test.
   initial begin
      #800000;
      miscompares++;
      conclude();
   end

   initial begin : main
      logic [15:0] d, c;
      int e;
      {st, sp, mlb, dwr, tog, esel, wdata} = '0;
      mode = ECIC_MODE_EVENT;
      sts = STS_EDGE;
      uen = 1'b1;
      rst = 1'b1;
      tick(20);
      rst = 1'b0;
      tick(1);
      // Event mode: the mode register only changes while stopped.
      for (int s = 0; s < 4; s++) begin
         esel = s[1:0];
         d = 16'(lf[1:0]);
         lf = step(lf);
         wdata = d;
         pulse(dwr);
         tick(1);
         e = irqs;
         pulse(st);
         tick(3);
         chk({15'h0000, en}, 16'h0001);
         chk(cnt, d);
         c = d;
         for (int k = 0; k < 9; k++) begin
            if (k == 4) begin
               d = 16'(lf[2:0]);
               lf = step(lf);
               wdata = d;
               pulse(dwr);
            end
            pulse(tog);
            tick(8);
            if (hits(esel, pin)) begin
               if (c == 16'h0000) begin
                  c = d;
                  e++;
               end else begin
                  c--;
               end
            end
            chk(cnt, c);
            chk(16'(irqs), 16'(e));
         end
         pulse(sp);
         tick(2);
         chk({15'h0000, en}, 16'h0000);
         pulse(tog);
         tick(8);
         chk(cnt, c);
      end
      // Capture mode, no interrupt at start; only edge bits may change while running.
      mode = ECIC_MODE_CAPTURE;
      esel = EDGE_BOTH;
      e = irqs;
      pulse(st);
      tick(3);
      chk(16'(irqs), 16'(e));
      c = cnt;
      tick(10);
      chk(cnt, c + 16'h000A);
      for (int k = 0; k < 3; k++) begin
         d = 16'(lf[5:0]) + 16'h0014;
         lf = step(lf);
         e = irqs;
         pulse(tog);
         tick(int'(d) - 1);
         pulse(tog);
         tick(8);
         chk(dat, d - 16'h0001);
         chk(stat, 16'h0000);
         chk(16'(irqs), 16'(e + 2));
      end
      e = irqs;
      pulse(st);
      tick(3);
      chk(16'(irqs), 16'(e + 1));
      // One wrap inside the interval: the low bits are kept and the flag set.
      pulse(tog);
      tick(65585);
      pulse(tog);
      tick(8);
      chk(dat, 16'h0031);
      chk(stat, 16'h0001);
      pulse(sp);
      tick(2);
      c = cnt;
      tick(5);
      chk(cnt, c);
      chk(stat, 16'h0001);
      mlb = 1'b1;
      e = irqs;
      pulse(st);
      tick(3);
      chk(16'(irqs), 16'(e + 1));
      // Unit off: a data write is dropped and everything returns to zero.
      uen = 1'b0;
      mode = ECIC_MODE_EVENT;
      wdata = 16'h1234;
      pulse(dwr);
      tick(1);
      uen = 1'b1;
      tick(2);
      chk(dat, 16'h0000);
      chk(cnt, 16'h0000);
      chk(stat, 16'h0000);
      chk({15'h0000, en}, 16'h0000);
      conclude();
   end
endmodule // test_event_count_and_interval_capture
